// file: uart_rx_pkg.sv
package uart_rx_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_BAUD_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_RECEIVE_DATA_BUFFER = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_RECEIVE_STATUS_CONTROL = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_BAUD_DIVISOR_LOW = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_BAUD_DIVISOR_HIGH = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_TRANSMIT_STATUS_CONTROL = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_INTERRUPT_ENABLE = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_EVENT_STATUS = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_EVENT_MASK = 8'h20;

    // receive_status_control fields
    localparam int SERIAL_PORT_ENABLE_BIT = 7;
    localparam int NINE_BIT_RECEIVE_SELECT_BIT = 6;
    localparam int SINGLE_RECEIVE_ENABLE_BIT = 5;
    localparam int CONTINUOUS_RECEIVE_ENABLE_BIT = 4;
    localparam int ADDRESS_DETECT_ENABLE_BIT = 3;
    localparam int FRAMING_ERROR_FLAG_BIT = 2;
    localparam int OVERRUN_ERROR_FLAG_BIT = 1;
    localparam int RECEIVED_NINTH_BIT_BIT = 0;
    // transmit_status_control fields
    localparam int CLOCKED_MODE_SELECT_BIT = 4;
    localparam int HIGH_SPEED_BAUD_SELECT_BIT = 2;
    localparam int SHIFT_EMPTY_BIT = 1;
    localparam logic [7:0] TRANSMIT_STATUS_CONTROL_WRITE_MASK = 8'hfd;
    // baud_control fields
    localparam int AUTOBAUD_OVERFLOW_BIT = 7;
    localparam int RECEIVER_IDLE_FLAG_BIT = 6;
    localparam int WIDE_DIVISOR_SELECT_BIT = 3;
    localparam int AUTOBAUD_ENABLE_BIT = 0;
    localparam logic [7:0] BAUD_CONTROL_WRITE_MASK = 8'h1b;
    // interrupt_enable fields
    localparam int GLOBAL_INTERRUPT_ENABLE_BIT = 7;
    localparam int PERIPHERAL_INTERRUPT_ENABLE_BIT = 6;
    localparam int RECEIVE_INTERRUPT_ENABLE_BIT = 5;
    // event_status / event_mask fields
    localparam int EVT_W = 4;
    localparam int EVT_CHAR_BIT = 0;
    localparam int EVT_OVERRUN_BIT = 1;
    localparam int EVT_FRAMING_BIT = 2;
    localparam int EVT_AUTOBAUD_BIT = 3;

    localparam logic [7:0] RECEIVE_STATUS_CONTROL_RESET = 8'h00;
    localparam logic [7:0] TRANSMIT_STATUS_CONTROL_RESET = 8'h00;
    localparam logic [7:0] BAUD_CONTROL_RESET = 8'h00;
    localparam logic [15:0] DIVISOR_RESET = 16'h0000;
    localparam logic [7:0] IEN_RESET = 8'h00;
    localparam logic [EVT_W-1:0] EVT_RESET = 4'h0;

    localparam int FIFO_DEPTH = 2;
    localparam int PERIOD_W = 22;
    localparam int AB_CNT_W = 24;
    // Falling edges after the first that close the autobaud window (8 bits)
    localparam logic [2:0] AB_EDGES = 3'd4;
    localparam logic [2:0] SHIFT_BOTH = 3'd2;
    localparam logic [2:0] SHIFT_ONE = 3'd4;
    localparam logic [2:0] SHIFT_NONE = 3'd6;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_STOP
    } rx_state_t;
endpackage : uart_rx_pkg

// file: async_rx_address_detect.sv
// Overview of operation
// - Address mode stores only ninth-bit-set characters
// - Character interrupt needs pending flag and receive enable
// - Address-mode characters report ninth bit one
// - Data read returns oldest character low byte
// - Clearing continuous receive clears overrun flag
// - Without address mode every character stored while the buffer has room and no overrun stands
// - Asynchronous receive only with clocked mode zero
// - Character interrupt needs receive, peripheral, global enables
// - Autobaud measurement rewrites the baud divisor
// - Two-deep buffer; third character sets overrun
// - Start checked at half bit, glitch dropped
// - Zero stop sample marks framing error
module async_rx_address_detect (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [uart_rx_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic receive_pin,
    output logic receive_pending_flag,
    output logic irq
);
    import uart_rx_pkg::*;

    typedef struct packed {
        rx_state_t st;
        logic [PERIOD_W-1:0] cnt;
        logic [3:0] bitn;
        logic [8:0] shreg;
        logic [2:0] hist;
        logic [1:0][9:0] fifo;
        logic [1:0] fcount;
        logic [7:0] receive_status_control;
        logic [7:0] transmit_status_control;
        logic [7:0] baud_control;
        logic [15:0] div;
        logic [7:0] ien;
        logic [EVT_W-1:0] evt;
        logic [EVT_W-1:0] mask;
        logic ab_run;
        logic [2:0] ab_edges;
        logic [AB_CNT_W-1:0] ab_cnt;
        logic [31:0] prdata;
    } state_t;

    state_t state_reg;
    state_t state_next;

    function automatic logic [2:0] mult_shift(input logic wide, input logic fast);
        if (wide && fast) begin
            return SHIFT_BOTH;
        end else if (wide || fast) begin
            return SHIFT_ONE;
        end
        return SHIFT_NONE;
    endfunction : mult_shift

    function automatic logic [PERIOD_W-1:0] bit_period(input logic [15:0] dv,
                                                       input logic wide, input logic fast);
        logic [16:0] n1;
        n1 = wide ? ({1'b0, dv} + 17'd1) : ({9'h000, dv[7:0]} + 17'd1);
        return {5'h00, n1} << mult_shift(wide, fast);
    endfunction : bit_period

    logic maj;
    logic fall;
    logic rx_on;
    logic addr_mode;
    logic [PERIOD_W-1:0] period;
    logic wr;
    logic rd_acc;
    logic setup_rd;
    logic mapped;
    logic [7:0] rd_val;
    logic [9:0] top;
    logic [9:0] entry;
    logic accept;
    logic [AB_CNT_W-1:0] ab_div;

    assign maj = (state_reg.hist[0] & state_reg.hist[1]) | (state_reg.hist[0] & state_reg.hist[2])
               | (state_reg.hist[1] & state_reg.hist[2]);
    assign fall = state_reg.hist[0] & ~receive_pin;
    assign rx_on = state_reg.receive_status_control[SERIAL_PORT_ENABLE_BIT]
                 & state_reg.receive_status_control[CONTINUOUS_RECEIVE_ENABLE_BIT]
                 & ~state_reg.transmit_status_control[CLOCKED_MODE_SELECT_BIT]
                 & ~state_reg.baud_control[AUTOBAUD_ENABLE_BIT];
    // Address detection only means something with nine-bit frames
    assign addr_mode = state_reg.receive_status_control[ADDRESS_DETECT_ENABLE_BIT]
                     & state_reg.receive_status_control[NINE_BIT_RECEIVE_SELECT_BIT];
    assign period = bit_period(state_reg.div, state_reg.baud_control[WIDE_DIVISOR_SELECT_BIT],
                               state_reg.transmit_status_control[HIGH_SPEED_BAUD_SELECT_BIT]);
    assign wr = psel & penable & pwrite;
    assign rd_acc = psel & penable & ~pwrite;
    assign setup_rd = psel & ~penable & ~pwrite;
    assign top = state_reg.fifo[0];
    // Four-bit shift sum: three bits would wrap for the slowest multiplier
    assign ab_div = state_reg.ab_cnt
                  >> ({1'b0, mult_shift(state_reg.baud_control[WIDE_DIVISOR_SELECT_BIT],
                                        state_reg.transmit_status_control[HIGH_SPEED_BAUD_SELECT_BIT])} + 4'd3);

    always_comb begin
        mapped = 1'b1;
        rd_val = 8'h00;
        unique case (paddr)
            OFS_BAUD_CONTROL: begin
                rd_val = state_reg.baud_control;
                // A start not yet verified still counts as idle
                rd_val[RECEIVER_IDLE_FLAG_BIT] = (state_reg.st == RX_IDLE)
                                               | (state_reg.st == RX_START);
            end
            OFS_RECEIVE_DATA_BUFFER: rd_val = state_reg.fcount != 2'd0 ? top[7:0] : 8'h00;
            OFS_RECEIVE_STATUS_CONTROL: begin
                rd_val = state_reg.receive_status_control;
                if (state_reg.fcount != 2'd0) begin
                    rd_val[FRAMING_ERROR_FLAG_BIT] = top[9];
                    rd_val[RECEIVED_NINTH_BIT_BIT] = top[8];
                end
            end
            OFS_BAUD_DIVISOR_LOW: rd_val = state_reg.div[7:0];
            OFS_BAUD_DIVISOR_HIGH: rd_val = state_reg.div[15:8];
            OFS_TRANSMIT_STATUS_CONTROL: begin
                rd_val = state_reg.transmit_status_control;
                rd_val[SHIFT_EMPTY_BIT] = 1'b1;
            end
            OFS_INTERRUPT_ENABLE: rd_val = state_reg.ien;
            OFS_EVENT_STATUS: rd_val = {4'h0, state_reg.evt};
            OFS_EVENT_MASK: rd_val = {4'h0, state_reg.mask};
            default: mapped = 1'b0;
        endcase
    end

    always_comb begin
        state_next = state_reg;
        entry = 10'h000;
        accept = 1'b0;
        state_next.hist = {state_reg.hist[1:0], receive_pin};
        if (setup_rd) begin
            state_next.prdata = {24'h000000, rd_val};
        end

        if (wr && mapped) begin
            unique case (paddr)
                OFS_BAUD_CONTROL: begin
                    state_next.baud_control = (state_reg.baud_control & ~BAUD_CONTROL_WRITE_MASK)
                                       | (pwdata[7:0] & BAUD_CONTROL_WRITE_MASK);
                    if (!pwdata[AUTOBAUD_OVERFLOW_BIT]) begin
                        state_next.baud_control[AUTOBAUD_OVERFLOW_BIT] = 1'b0;
                    end
                end
                OFS_RECEIVE_STATUS_CONTROL: begin
                    state_next.receive_status_control[7:3] = pwdata[7:3];
                    if (!pwdata[CONTINUOUS_RECEIVE_ENABLE_BIT]) begin
                        state_next.receive_status_control[OVERRUN_ERROR_FLAG_BIT] = 1'b0;
                    end
                end
                OFS_BAUD_DIVISOR_LOW: state_next.div[7:0] = pwdata[7:0];
                OFS_BAUD_DIVISOR_HIGH: state_next.div[15:8] = pwdata[7:0];
                OFS_TRANSMIT_STATUS_CONTROL: state_next.transmit_status_control = pwdata[7:0] & TRANSMIT_STATUS_CONTROL_WRITE_MASK;
                OFS_INTERRUPT_ENABLE: state_next.ien = {pwdata[7:5], 5'h00};
                OFS_EVENT_STATUS: state_next.evt = state_reg.evt & ~pwdata[EVT_W-1:0];
                OFS_EVENT_MASK: state_next.mask = pwdata[EVT_W-1:0];
                default: state_next.mask = state_reg.mask;
            endcase
        end

        // Pop the oldest character when its data byte is read
        if (rd_acc && paddr == OFS_RECEIVE_DATA_BUFFER && state_reg.fcount != 2'd0) begin
            state_next.fifo[0] = state_reg.fifo[1];
            state_next.fcount = state_reg.fcount - 2'd1;
        end

        unique case (state_reg.st)
            RX_IDLE: begin
                if (rx_on && fall) begin
                    state_next.st = RX_START;
                    state_next.cnt = (period >> 1) - 22'd1;
                end
            end
            RX_START: begin
                if (state_reg.cnt != '0) begin
                    state_next.cnt = state_reg.cnt - 22'd1;
                end else if (!maj) begin
                    state_next.st = RX_DATA;
                    state_next.cnt = period - 22'd1;
                    state_next.bitn = 4'd0;
                end else begin
                    state_next.st = RX_IDLE;
                end
            end
            RX_DATA: begin
                if (state_reg.cnt != '0) begin
                    state_next.cnt = state_reg.cnt - 22'd1;
                end else begin
                    state_next.shreg = {maj, state_reg.shreg[8:1]};
                    state_next.cnt = period - 22'd1;
                    state_next.bitn = state_reg.bitn + 4'd1;
                    if (state_reg.bitn == (state_reg.receive_status_control[NINE_BIT_RECEIVE_SELECT_BIT] ? 4'd8 : 4'd7)) begin
                        state_next.st = RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                if (state_reg.cnt != '0) begin
                    state_next.cnt = state_reg.cnt - 22'd1;
                end else begin
                    state_next.st = RX_IDLE;
                    entry[9] = ~maj;
                    if (state_reg.receive_status_control[NINE_BIT_RECEIVE_SELECT_BIT]) begin
                        entry[8:0] = state_reg.shreg;
                    end else begin
                        entry[8:0] = {1'b0, state_reg.shreg[8:1]};
                    end
                    accept = rx_on & (~addr_mode | entry[8]);
                    // While overrun stands the character is lost by design
                    if (accept && !state_reg.receive_status_control[OVERRUN_ERROR_FLAG_BIT]) begin
                        if (state_next.fcount == 2'(FIFO_DEPTH)) begin
                            state_next.receive_status_control[OVERRUN_ERROR_FLAG_BIT] = 1'b1;
                            state_next.evt[EVT_OVERRUN_BIT] = 1'b1;
                        end else begin
                            state_next.fifo[state_next.fcount[0]] = entry;
                            state_next.fcount = state_next.fcount + 2'd1;
                            state_next.evt[EVT_CHAR_BIT] = 1'b1;
                            state_next.evt[EVT_FRAMING_BIT] = state_next.evt[EVT_FRAMING_BIT]
                                                            | entry[9];
                        end
                    end
                end
            end
        endcase

        // Autobaud: 8 bit times between the 1st and 5th falling edge
        if (state_reg.receive_status_control[SERIAL_PORT_ENABLE_BIT] && state_reg.baud_control[AUTOBAUD_ENABLE_BIT]) begin
            if (state_reg.ab_run) begin
                state_next.ab_cnt = state_reg.ab_cnt + 24'd1;
                if (&state_reg.ab_cnt) begin
                    state_next.baud_control[AUTOBAUD_OVERFLOW_BIT] = 1'b1;
                    state_next.baud_control[AUTOBAUD_ENABLE_BIT] = 1'b0;
                    state_next.ab_run = 1'b0;
                end else if (fall) begin
                    state_next.ab_edges = state_reg.ab_edges + 3'd1;
                    if (state_reg.ab_edges == AB_EDGES - 3'd1) begin
                        state_next.div = ab_div[15:0] - 16'd1;
                        state_next.baud_control[AUTOBAUD_ENABLE_BIT] = 1'b0;
                        state_next.ab_run = 1'b0;
                        state_next.evt[EVT_AUTOBAUD_BIT] = 1'b1;
                    end
                end
            end else if (fall) begin
                state_next.ab_run = 1'b1;
                // Start at one so the count at the fifth edge is the full span
                state_next.ab_cnt = AB_CNT_W'(1);
                state_next.ab_edges = 3'd0;
            end
        end else begin
            state_next.ab_run = 1'b0;
        end

        // Port disable resets the receiver, buffer and error flags
        if (!state_next.receive_status_control[SERIAL_PORT_ENABLE_BIT] || !state_reg.receive_status_control[SERIAL_PORT_ENABLE_BIT]) begin
            if (!state_next.receive_status_control[SERIAL_PORT_ENABLE_BIT]) begin
                state_next.st = RX_IDLE;
                state_next.fcount = 2'd0;
                state_next.receive_status_control[OVERRUN_ERROR_FLAG_BIT] = 1'b0;
                state_next.ab_run = 1'b0;
            end
        end
        if (state_reg.st != RX_IDLE && !rx_on) begin
            state_next.st = RX_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '{st: RX_IDLE, cnt: '0, bitn: 4'h0, shreg: 9'h000, hist: 3'h7,
                           fifo: '0, fcount: 2'h0, receive_status_control: RECEIVE_STATUS_CONTROL_RESET, transmit_status_control: TRANSMIT_STATUS_CONTROL_RESET,
                           baud_control: BAUD_CONTROL_RESET, div: DIVISOR_RESET, ien: IEN_RESET,
                           evt: EVT_RESET, mask: EVT_RESET, ab_run: 1'b0, ab_edges: 3'h0,
                           ab_cnt: '0, prdata: 32'h00000000};
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata = state_reg.prdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign receive_pending_flag = state_reg.fcount != 2'd0;
    // Character-pending request plus masked sticky events, all behind the two top gates
    assign irq = state_reg.ien[GLOBAL_INTERRUPT_ENABLE_BIT]
               & state_reg.ien[PERIPHERAL_INTERRUPT_ENABLE_BIT]
               & ((receive_pending_flag & state_reg.ien[RECEIVE_INTERRUPT_ENABLE_BIT])
                  | (|(state_reg.evt & state_reg.mask)));
endmodule : async_rx_address_detect

// file: async_rx_address_detect_props.sv
module async_rx_address_detect_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [uart_rx_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic receive_pin,
    input wire logic receive_pending_flag,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    import uart_rx_pkg::*;
    typedef struct packed {
        logic [7:0] ien;
        logic [EVT_W-1:0] mask;
        logic serial_port_enable;
        logic continuous_receive_enable;
        logic clocked;
    } shadow_t;
    shadow_t sh_reg, sh_next;
    logic wr_commit, mapped, run_ok, data_read;
    assign wr_commit = psel && penable && pwrite && pready;
    assign data_read = psel && penable && !pwrite && paddr == OFS_RECEIVE_DATA_BUFFER;
    // Offsets are word-aligned and contiguous up to the mask register
    assign mapped = paddr[1:0] == 2'h0 && paddr <= OFS_EVENT_MASK;
    assign run_ok = sh_reg.serial_port_enable && sh_reg.continuous_receive_enable && !sh_reg.clocked;
    // Mirrors of software-written controls, updated on the same edge as the design
    always_comb begin
        sh_next = sh_reg;
        if (wr_commit && paddr == OFS_INTERRUPT_ENABLE) sh_next.ien = pwdata[7:0];
        if (wr_commit && paddr == OFS_EVENT_MASK) sh_next.mask = pwdata[EVT_W-1:0];
        if (wr_commit && paddr == OFS_TRANSMIT_STATUS_CONTROL) sh_next.clocked = pwdata[4];
        if (wr_commit && paddr == OFS_RECEIVE_STATUS_CONTROL) begin
            sh_next.serial_port_enable = pwdata[SERIAL_PORT_ENABLE_BIT];
            sh_next.continuous_receive_enable = pwdata[CONTINUOUS_RECEIVE_ENABLE_BIT];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) sh_reg <= '0;
        else sh_reg <= sh_next;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_high: assert property (pready) else $error("pready low");
    chk_err_decode: assert property (psel && penable |-> pslverr == !mapped)
        else $error("pslverr decode wrong");
    chk_upper_zero: assert property (prdata[31:8] == 24'h0) else $error("prdata upper bits set");
    chk_bad_read: assert property (psel && penable && !pwrite && !mapped |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    chk_irq_enables: assert property (!(sh_reg.ien[7] && sh_reg.ien[6]) |-> !irq)
        else $error("irq without global and peripheral enable");
    chk_irq_exact: assert property (sh_reg.mask == '0 |->
        irq == (sh_reg.ien[7] && sh_reg.ien[6] && sh_reg.ien[5] && receive_pending_flag))
        else $error("irq does not follow pending and enables");
    chk_serial_port_enable_empties: assert property (!sh_reg.serial_port_enable |-> !receive_pending_flag)
        else $error("pending while port disabled");
    chk_store_gate: assert property ($rose(receive_pending_flag) |-> $past(run_ok))
        else $error("character stored while receiver off");
    chk_pop_only: assert property ($fell(receive_pending_flag) |->
        $past(data_read) || !sh_reg.serial_port_enable) else $error("pending dropped without a read");
endmodule : async_rx_address_detect_props

bind async_rx_address_detect async_rx_address_detect_props chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .receive_pin(receive_pin), .receive_pending_flag(receive_pending_flag), .irq(irq));

// file: remote_tx_model.sv
module remote_tx_model #(
    parameter int BIT_CYCLES = 16
) (
    input wire logic pclk,
    output logic receive_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // Biased line rests high between frames
    initial receive_pin = 1'b1;
    task automatic hold_bit(input logic level);
        receive_pin <= level;
        repeat (BIT_CYCLES) @(posedge pclk);
    endtask : hold_bit
    task automatic send(input logic [8:0] ch, input logic nine, input logic stop_level);
        @(posedge pclk);
        hold_bit(1'b0);
        for (int i = 0; i < 9; i++) begin
            if (i < 8 || nine) hold_bit(ch[i]);
        end
        hold_bit(stop_level);
        receive_pin <= 1'b1;
    endtask : send
    // Low pulse shorter than half a bit, then quiet line
    task automatic glitch(input int low_cycles);
        @(posedge pclk);
        receive_pin <= 1'b0;
        repeat (low_cycles) @(posedge pclk);
        receive_pin <= 1'b1;
        repeat (2 * BIT_CYCLES) @(posedge pclk);
    endtask : glitch
endmodule : remote_tx_model

// file: async_rx_address_detect_tb_top.sv
module async_rx_address_detect_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import uart_rx_pkg::*;
    localparam logic [7:0] DIV = 8'h03;
    // Wide and fast divisor: (n+1)*4 cycles per bit
    localparam int BIT_CYCLES = (DIV + 1) * 4;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, receive_pin;
    logic receive_pending_flag, irq, rerr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    int n_fail = 0;
    int n_checks = 0;
    int cycles = 0;
    async_rx_address_detect dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .receive_pin(receive_pin),
        .receive_pending_flag(receive_pending_flag), .irq(irq));
    remote_tx_model #(.BIT_CYCLES(BIT_CYCLES)) line (.pclk(pclk), .receive_pin(receive_pin));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask : wr
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic take(input logic [7:0] exp, input logic ninth);
        rd(OFS_RECEIVE_STATUS_CONTROL);
        check("ninth bit", rdat[RECEIVED_NINTH_BIT_BIT], ninth);
        rd(OFS_RECEIVE_DATA_BUFFER);
        check("data byte", rdat, {24'h0, exp});
    endtask : take
    task automatic t_reset_regs;
        rd(OFS_RECEIVE_STATUS_CONTROL);
        check("status reset", rdat, 32'h0);
        rd(OFS_TRANSMIT_STATUS_CONTROL);
        check("transmit_status_control reset", rdat, 32'h2);
        rd(OFS_BAUD_CONTROL);
        check("idle at rest", rdat[RECEIVER_IDLE_FLAG_BIT], 1'b1);
        rd(8'h24);
        check("unmapped err", rerr, 1'b1);
        check("unmapped data", rdat, 32'h0);
    endtask : t_reset_regs
    task automatic t_setup;
        wr(OFS_BAUD_DIVISOR_LOW, DIV);
        wr(OFS_BAUD_DIVISOR_HIGH, 8'h00);
        wr(OFS_TRANSMIT_STATUS_CONTROL, 8'h04);
        wr(OFS_BAUD_CONTROL, 8'h08);
        wr(OFS_RECEIVE_STATUS_CONTROL, 8'h80);
        wr(OFS_RECEIVE_STATUS_CONTROL, 8'hc0);
        wr(OFS_RECEIVE_STATUS_CONTROL, 8'hc8);
        wr(OFS_RECEIVE_STATUS_CONTROL, 8'hd8);
    endtask : t_setup
    task automatic t_address_mode;
        line.send(9'h055, 1'b1, 1'b1);
        @(negedge pclk);
        check("data char dropped", receive_pending_flag, 1'b0);
        line.send(9'h1a5, 1'b1, 1'b1);
        @(negedge pclk);
        check("address pending", receive_pending_flag, 1'b1);
        take(8'ha5, 1'b1);
        @(negedge pclk);
        check("buffer emptied", receive_pending_flag, 1'b0);
    endtask : t_address_mode
    task automatic t_data_mode;
        wr(OFS_RECEIVE_STATUS_CONTROL, 8'hd0);
        line.send(9'h03c, 1'b1, 1'b1);
        @(negedge pclk);
        check("plain char pending", receive_pending_flag, 1'b1);
        take(8'h3c, 1'b0);
    endtask : t_data_mode
    task automatic t_overrun;
        line.send(9'h011, 1'b1, 1'b1);
        line.send(9'h122, 1'b1, 1'b1);
        line.send(9'h033, 1'b1, 1'b1);
        line.send(9'h044, 1'b1, 1'b1);
        rd(OFS_RECEIVE_STATUS_CONTROL);
        check("overrun set", rdat[OVERRUN_ERROR_FLAG_BIT], 1'b1);
        take(8'h11, 1'b0);
        take(8'h22, 1'b1);
        @(negedge pclk);
        check("third dropped", receive_pending_flag, 1'b0);
        wr(OFS_RECEIVE_STATUS_CONTROL, 8'hc0);
        rd(OFS_RECEIVE_STATUS_CONTROL);
        check("overrun cleared", rdat[OVERRUN_ERROR_FLAG_BIT], 1'b0);
        wr(OFS_RECEIVE_STATUS_CONTROL, 8'hd0);
        line.send(9'h155, 1'b1, 1'b1);
        take(8'h55, 1'b1);
    endtask : t_overrun
    task automatic t_frame_glitch;
        line.glitch(3);
        @(negedge pclk);
        check("glitch ignored", receive_pending_flag, 1'b0);
        fork
            line.send(9'h0f0, 1'b1, 1'b0);
            begin
                repeat (3 * BIT_CYCLES) @(posedge pclk);
                rd(OFS_BAUD_CONTROL);
                check("busy in frame", rdat[RECEIVER_IDLE_FLAG_BIT], 1'b0);
            end
        join
        rd(OFS_RECEIVE_STATUS_CONTROL);
        check("framing set", rdat[FRAMING_ERROR_FLAG_BIT], 1'b1);
        take(8'hf0, 1'b0);
        line.send(9'h00f, 1'b1, 1'b1);
        rd(OFS_RECEIVE_STATUS_CONTROL);
        check("framing clear", rdat[FRAMING_ERROR_FLAG_BIT], 1'b0);
        take(8'h0f, 1'b0);
    endtask : t_frame_glitch
    task automatic t_autobaud;
        wr(OFS_BAUD_DIVISOR_LOW, 8'h00);
        wr(OFS_BAUD_CONTROL, 8'h09);
        line.send(9'h055, 1'b0, 1'b1);
        rd(OFS_BAUD_DIVISOR_LOW);
        check("measured divisor", rdat, {24'h0, DIV});
        rd(OFS_BAUD_CONTROL);
        check("autobaud done", rdat[AUTOBAUD_ENABLE_BIT], 1'b0);
        rd(OFS_EVENT_STATUS);
        check("autobaud event", rdat[EVT_AUTOBAUD_BIT], 1'b1);
    endtask : t_autobaud
    task automatic t_irq;
        line.send(9'h0aa, 1'b1, 1'b1);
        for (int i = 0; i < 8; i++) begin
            wr(OFS_INTERRUPT_ENABLE, {i[2:0], 5'h00});
            @(negedge pclk);
            check("irq gate", irq, i == 7);
        end
        wr(OFS_INTERRUPT_ENABLE, 8'hc0);
        wr(OFS_EVENT_MASK, 8'h01);
        @(negedge pclk);
        check("event irq", irq, 1'b1);
        wr(OFS_EVENT_STATUS, 8'h01);
        @(negedge pclk);
        check("event cleared", irq, 1'b0);
        wr(OFS_EVENT_MASK, 8'h00);
        take(8'haa, 1'b0);
    endtask : t_irq
    task automatic conclude;
        if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Whole run needs a few thousand cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 30000) begin
            n_fail++;
            conclude;
        end
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_regs;
        t_setup;
        t_address_mode;
        t_data_mode;
        t_overrun;
        t_frame_glitch;
        t_autobaud;
        t_irq;
        conclude;
    end
endmodule : async_rx_address_detect_tb_top
